// file: common/dpram_port_pkg.sv
// constants for one port of the synchronous dual-port static ram
package dpram_port_pkg;
  localparam int ADDR_W = 14;
  localparam int DATA_W = 18;
  localparam int LANE_LO_TOP = 8;
  localparam int LANE_HI_BOT = 9;
  localparam logic [13:0] ADDR_ZERO = 14'h0000;
  localparam logic [17:0] DATA_ZERO = 18'h00000;
  // clock period and minimum cycle times, slowest grade, in ns
  localparam int CLK_PERIOD_NS = 50;
  localparam int FLOW_CYCLE_TIME_NS = 30;
  localparam int PIPE_CYCLE_TIME_NS = 20;
  localparam int FLOW_CYCLE_CLKS =
    (FLOW_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PIPE_CYCLE_CLKS =
    (PIPE_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic MODE_PIPE = 1'b1;
endpackage

// file: hw/dpram_port.sv
// one port of a 16k x 18 synchronous dual-port ram, memory array included
// Behaviour
// - mode pin high pipelined, low flow-through
// - all inputs clocked except output enable, mode
// - deselect floats outputs next edge flow-through, second edge pipelined; inactive lane floats them next edge
// - low strobe loads external address every edge unless clear is low
// - flow-through reads drive only lanes whose select is active; pipelined reads drive the lanes selected one cycle after the read
// - flow-through cross-port read valid after write
// - pipelined cross-port read may slip one cycle
// - chip enables two stages pipelined, one flow
// - pipelined data one cycle after flow-through
// - counter steps on enable low, strobe high
// - counter clear forces address zero same cycle
`timescale 1ns/1ns
`default_nettype none
module dpram_port #(
  parameter int AW = dpram_port_pkg::ADDR_W,
  parameter int DW = dpram_port_pkg::DATA_W
) (
  input  wire logic          clk,
  input  wire logic          rstn,
  input  wire logic          chip_select_n,
  input  wire logic          chip_select_hi,
  input  wire logic          upper_lane_sel_n,
  input  wire logic          lower_lane_sel_n,
  input  wire logic          write_n,
  input  wire logic          out_en_n,
  input  wire logic          out_mode_sel,
  input  wire logic          addr_load_n,
  input  wire logic          addr_step_en_n,
  input  wire logic          addr_clear_n,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] data_in,
  output logic      [DW-1:0] data_out,
  output logic      [DW-1:0] data_oe,
  output logic      [AW-1:0] cur_addr
);
  localparam int LO = dpram_port_pkg::LANE_LO_TOP;
  localparam int HI = dpram_port_pkg::LANE_HI_BOT;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] flow_q;
    logic [DW-1:0] pipe_q;
    logic          sel1;
    logic          sel2;
    logic          up1;
    logic          lo1;
    logic          up2;
    logic          lo2;
    logic          rd1;
    logic          rd2;
  } state_t;

  logic [DW-1:0] mem [2**AW];
  state_t st_ff;
  state_t nxt_st;
  logic [AW-1:0] acc_addr;
  logic          sel_now;
  logic          do_wr;

  // counter wraps from the top word back to zero
  function automatic logic [AW-1:0] next_addr(input logic [AW-1:0] a);
    next_addr = AW'(a + 1'b1);
  endfunction

  // device is a synchronous part: its pins except output enable and mode are sampled on clk directly
  always_comb begin
    nxt_st = st_ff;
    if (!addr_clear_n) begin
      acc_addr = dpram_port_pkg::ADDR_ZERO;
    end else if (!addr_load_n) begin
      acc_addr = addr;
    end else if (!addr_step_en_n) begin
      acc_addr = next_addr(st_ff.addr);
    end else begin
      acc_addr = st_ff.addr;
    end
    sel_now = !chip_select_n && chip_select_hi;
    do_wr = sel_now && !write_n;
    nxt_st.addr = acc_addr;
    // a write lands in the array at its own edge, so a read one edge
    // later sees it; the far port's clock offset is the far port's
    // concern, only this port's pipeline timing is modelled
    nxt_st.flow_q = mem[acc_addr];
    nxt_st.pipe_q = st_ff.flow_q;
    nxt_st.sel1 = sel_now;
    nxt_st.sel2 = st_ff.sel1;
    nxt_st.up1 = !upper_lane_sel_n;
    nxt_st.lo1 = !lower_lane_sel_n;
    // byte selects are single buffered in both modes
    nxt_st.up2 = !upper_lane_sel_n;
    nxt_st.lo2 = !lower_lane_sel_n;
    nxt_st.rd1 = sel_now && write_n;
    nxt_st.rd2 = st_ff.rd1;
    if (!rstn) begin
      nxt_st = '0;
    end
  end

  // memory write: read before write on this port; other port not modelled
  always_ff @(posedge clk) begin
    if (do_wr && !upper_lane_sel_n) begin
      mem[acc_addr][DW-1:HI] <= data_in[DW-1:HI];
    end
    if (do_wr && !lower_lane_sel_n) begin
      mem[acc_addr][LO:0] <= data_in[LO:0];
    end
  end

  always_ff @(posedge clk) begin
    st_ff <= nxt_st;
  end

  logic pipe_mode;
  logic drive_on;
  logic up_on;
  logic lo_on;
  assign pipe_mode = (out_mode_sel == dpram_port_pkg::MODE_PIPE);
  // mode pin and output enable act combinationally on the drivers
  assign drive_on = !out_en_n && (pipe_mode ? (st_ff.sel2 && st_ff.rd2)
                                            : (st_ff.sel1 && st_ff.rd1));
  assign up_on = drive_on && st_ff.up1;
  assign lo_on = drive_on && st_ff.lo1;
  assign data_out = pipe_mode ? st_ff.pipe_q : st_ff.flow_q;
  assign data_oe = {{(DW-HI){up_on}}, {(LO+1){lo_on}}};
  assign cur_addr = st_ff.addr;

  // one clock domain; antecedents of checks a zeroed state could fail carry rstn so that a reset edge,
  // which zeroes the state, never starts a check that ends after release
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rstn);

  // address path
  a_clear_zero: assert property (
    !addr_clear_n
    |=> cur_addr == '0)
    else $error("counter clear did not give address zero");
  a_clear_write: assert property (
    rstn && !addr_clear_n && do_wr && !lower_lane_sel_n
    |=> mem[dpram_port_pkg::ADDR_ZERO][LO:0] == $past(data_in[LO:0]))
    else $error("write during counter clear missed address zero");
  a_load_addr: assert property (
    rstn && addr_clear_n && !addr_load_n
    |=> cur_addr == $past(addr))
    else $error("strobe did not load external address");
  a_step_addr: assert property (
    rstn && addr_clear_n && addr_load_n && !addr_step_en_n
    |=> cur_addr == next_addr($past(cur_addr)))
    else $error("counter did not step");
  a_hold_addr: assert property (
    rstn && addr_clear_n && addr_load_n && addr_step_en_n
    |=> $stable(cur_addr))
    else $error("counter did not hold");

  // output enable
  a_oe_float: assert property (
    out_en_n
    |-> data_oe == '0)
    else $error("outputs driven with output enable high");
  a_oe_return: assert property (
    rstn && !out_mode_sel && sel_now && write_n && !upper_lane_sel_n
    ##1 !out_mode_sel && $fell(out_en_n)
    |-> data_oe[DW-1:HI] == '1)
    else $error("outputs not re-enabled with output enable low");

  // deselect and lane floating
  a_flow_desel: assert property (
    !out_mode_sel && chip_select_n ##1 !out_mode_sel
    |-> data_oe == '0)
    else $error("flow-through deselect did not float outputs");
  a_flow_hi_low: assert property (
    !out_mode_sel && !chip_select_hi ##1 !out_mode_sel
    |-> data_oe == '0)
    else $error("flow-through enable low did not float outputs");
  a_pipe_desel: assert property (
    out_mode_sel && chip_select_n ##1 out_mode_sel ##1 out_mode_sel
    |-> data_oe == '0)
    else $error("pipelined deselect did not float after two cycles");
  a_pipe_hi_low: assert property (
    out_mode_sel && !chip_select_hi ##1 out_mode_sel ##1 out_mode_sel
    |-> data_oe == '0)
    else $error("pipelined enable low did not float after two cycles");
  a_write_quiet: assert property (
    !out_mode_sel && !write_n ##1 !out_mode_sel
    |-> data_oe == '0)
    else $error("write cycle drove the outputs");
  a_lane_upper: assert property (
    upper_lane_sel_n
    |=> data_oe[DW-1:HI] == '0)
    else $error("inactive upper lane driven");
  a_lane_lower: assert property (
    lower_lane_sel_n
    |=> data_oe[LO:0] == '0)
    else $error("inactive lower lane driven");

  // read latency per mode
  a_flow_drive: assert property (
    rstn && !out_mode_sel && sel_now && write_n && !upper_lane_sel_n
    ##1 !out_mode_sel && !out_en_n
    |-> data_oe[DW-1:HI] == '1)
    else $error("flow-through read not driven after one cycle");
  a_pipe_drive: assert property (
    rstn && out_mode_sel && sel_now && write_n
    ##1 rstn && out_mode_sel && !upper_lane_sel_n
    ##1 out_mode_sel && !out_en_n
    |-> data_oe[DW-1:HI] == '1)
    else $error("pipelined read not driven after two cycles");
  a_pipe_lag: assert property (
    rstn && out_mode_sel ##1 out_mode_sel
    |-> st_ff.pipe_q == $past(st_ff.flow_q))
    else $error("pipelined data not one cycle behind");

  // lane masked writes
  a_write_upper: assert property (
    rstn && do_wr && !upper_lane_sel_n
    |=> mem[cur_addr][DW-1:HI] == $past(data_in[DW-1:HI]))
    else $error("upper lane write did not land");
  a_write_lower: assert property (
    rstn && do_wr && !lower_lane_sel_n
    |=> mem[cur_addr][LO:0] == $past(data_in[LO:0]))
    else $error("lower lane write did not land");

  c_flow_read: cover property (
    !out_mode_sel && |data_oe);
  c_pipe_read: cover property (
    out_mode_sel && |data_oe);
  c_step: cover property (
    addr_load_n && !addr_step_en_n);
  c_clear: cover property (
    !addr_clear_n && addr_load_n);
  c_lane_write: cover property (
    do_wr && (upper_lane_sel_n != lower_lane_sel_n));
endmodule
`default_nettype wire

// file: verification/dpram_bus_model.sv
// data wire as the controller sees it
`timescale 1ns/1ns
`default_nettype none
module dpram_bus_model (
  input  wire logic        clk,
  input  wire logic [17:0] data_out,
  input  wire logic [17:0] data_oe,
  output logic      [17:0] bus
);
  logic [17:0] last_ff;
  // floating bits toggle so stale data never passes as a read
  assign bus = (data_out & data_oe) | (~last_ff & ~data_oe);
  always @(posedge clk) begin
    last_ff <= bus;
  end
endmodule
`default_nettype wire

// file: verification/dpram_port_tb.sv
// self-checking bench for one ram port
`timescale 1ns/1ns
`default_nettype none
module dpram_port_tb;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        oe_n = 1'b0;
  logic        mode = 1'b0;
  // cs_n cs_hi up_n lo_n wr_n load_n step_n clear_n
  logic [7:0]  ctl = 8'h4F;
  logic [13:0] addr = 14'h0000;
  logic [13:0] cur;
  logic [17:0] din = 18'h00000;
  logic [17:0] dout;
  logic [17:0] doe;
  logic [17:0] bus;
  int          fail_count = 0;
  int          checked = 0;
  int          cyc = 0;
  always #25 clk = ~clk;
  dpram_port i_dut (.clk(clk), .rstn(rstn), .chip_select_n(ctl[7]),
    .chip_select_hi(ctl[6]), .upper_lane_sel_n(ctl[5]),
    .lower_lane_sel_n(ctl[4]), .write_n(ctl[3]), .out_en_n(oe_n),
    .out_mode_sel(mode), .addr_load_n(ctl[2]), .addr_step_en_n(ctl[1]),
    .addr_clear_n(ctl[0]), .addr(addr), .data_in(din), .data_out(dout),
    .data_oe(doe), .cur_addr(cur));
  dpram_bus_model i_bus (.clk(clk), .data_out(dout), .data_oe(doe),
    .bus(bus));
  task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic op(input logic [7:0] c, input logic [13:0] a,
                    input logic [17:0] d = 18'h00000);
    @(posedge clk);
    ctl <= c;
    addr <= a;
    din <= d;
  endtask
  task automatic print_verdict;
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic t_flow;
    op(8'h43, 14'h0010);
    op(8'h53, 14'h0010, 18'h3FFFF);
    op(8'h43, 14'h0011);
    op(8'h63, 14'h0011, 18'h3FFFF);
    op(8'h4B, 14'h0010);
    op(8'h4B, 14'h0011);
    #1 chk(bus, 18'h3FE00);
    op(8'h5B, 14'h0010);
    #1 chk(bus, 18'h001FF);
    op(8'hCB, 14'h0010);
    #1 chk(doe, 18'h3FE00);
    op(8'h0B, 14'h0010);
    #1 chk(doe, 18'h00000);
    op(8'h4F, 14'h0010);
    #1 chk(doe, 18'h00000);
    op(8'h4F, 14'h0010);
    #1 chk(bus, 18'h3FE00);
    @(posedge clk);
    oe_n <= 1'b1;
    #1 chk(doe, 18'h00000);
    @(posedge clk);
    oe_n <= 1'b0;
    #1 chk(doe, 18'h3FFFF);
    $display("flow test done");
  endtask
  task automatic t_pipe;
    @(posedge clk);
    mode <= 1'b1;
    op(8'h4B, 14'h0011);
    op(8'hCB, 14'h0011);
    #1 chk(bus, 18'h3FE00);
    op(8'hCB, 14'h0011);
    #1 chk(bus, 18'h001FF);
    chk(doe, 18'h3FFFF);
    op(8'h4F, 14'h0011);
    #1 chk(doe, 18'h00000);
    $display("pipe test done");
  endtask
  task automatic t_count;
    op(8'h4A, 14'h3FFF);
    op(8'hCD, 14'h3FFF);
    #1 chk({4'h0, cur}, 18'h00000);
    op(8'h4F, 14'h3FFF);
    #1 chk({4'h0, cur}, 18'h00001);
    op(8'h4B, 14'h2000);
    #1 chk({4'h0, cur}, 18'h00001);
    op(8'h4F, 14'h0000);
    #1 chk({4'h0, cur}, 18'h02000);
    $display("counter test done");
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 500) begin
      fail_count++;
      print_verdict();
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    t_flow();
    t_pipe();
    t_count();
    print_verdict();
  end
endmodule
`default_nettype wire
